/* hdl/readout_pkg.sv */
package readout_pkg;

    localparam int WORD_W      = 16;
    localparam int BYTE_W      = 8;
    localparam int N_BITS      = 16;
    localparam int CORE_CLK_NS = 40;
    // least half period of the generated serial clock
    localparam int MS_HALF_NS  = 80;
    localparam int MS_HALF_CYC =
        (MS_HALF_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;
    // log2 of the bit-group size: each later group of 4 bits adds one half-period cycle
    localparam int MS_SLOW_SHIFT = 2;
    localparam logic [WORD_W-1:0] RESULT_RST = 16'h0000;

    typedef struct packed {
        logic serial;
        logic ext_clk;
        logic read_during;
        logic byte_swap;
        logic sclk_inv;
        logic sync_inv;
    } mode_t;

    localparam mode_t MODE_RST = '0;

    typedef enum logic [1:0] {
        MS_IDLE  = 2'b01,
        MS_SHIFT = 2'b10
    } ms_state_t;

endpackage

/* hdl/slave_link.sv */
`timescale 1ns/1ps
// logic running on the host's serial clock
module slave_link (
    input  wire logic                          sclk_in,
    input  wire logic                          rstn,
    input  wire logic                          cs_n,
    input  wire logic                          rd_n,
    input  wire logic                          cascade_en,
    input  wire logic [readout_pkg::WORD_W-1:0] word,
    input  wire logic                          cascade_in,
    output logic                               sdo,
    output logic                               done_tgl
);
    import readout_pkg::*;

    logic              link_clr_n;
    logic [4:0]        bit_cnt;
    logic [N_BITS-1:0] casc_dly;

    // clock is ignored unless select and read are both low
    assign link_clr_n = rstn & ~cs_n & ~rd_n;

    // count shift edges; falling edge moves to the next bit, so the bit
    // is stable around the rising edge and changes on the next falling one
    always_ff @(negedge sclk_in or negedge link_clr_n) begin
        if (!link_clr_n) begin
            bit_cnt <= 5'h00;
        end else if (bit_cnt != 5'(N_BITS)) begin
            bit_cnt <= bit_cnt + 5'h01;
        end
    end

    // event to core: a whole word has left the pin
    always_ff @(negedge sclk_in or negedge rstn) begin
        if (!rstn) begin
            done_tgl <= 1'b0;
        end else if (!cs_n && !rd_n && bit_cnt == 5'(N_BITS - 1)) begin
            done_tgl <= ~done_tgl;
        end
    end

    // cascade sampled on the edge opposite the shift edge
    always_ff @(posedge sclk_in or negedge rstn) begin
        if (!rstn) begin
            casc_dly <= '0;
        end else if (!cs_n && !rd_n) begin
            casc_dly <= {casc_dly[N_BITS-2:0], cascade_in};
        end
    end

    // msb shows before the first edge; upstream bits follow our lsb
    always_comb begin
        if (bit_cnt < 5'(N_BITS)) begin
            sdo = word[4'(N_BITS - 1) - bit_cnt[3:0]];
        end else begin
            sdo = cascade_en & casc_dly[N_BITS-1];
        end
    end

endmodule

/* hdl/adc_result_readout_port.sv */
`timescale 1ns/1ps
module adc_result_readout_port (
    input  wire logic                          core_clk,
    input  wire logic                          rstn,
    input  wire logic                          convert_start_n,
    input  wire logic                          cs_n,
    input  wire logic                          rd_n,
    input  wire logic                          serial_parallel_sel,
    input  wire logic                          clock_source_sel,
    input  wire logic                          byte_order_sel,
    input  wire logic                          sclk_invert_sel,
    input  wire logic                          sync_invert_sel,
    input  wire logic                          read_timing_or_cascade_in,
    input  wire logic                          sclk_in,
    output logic                               sclk_out,
    output logic                               sclk_oe_n,
    output logic                               sync_out,
    output logic                               serial_result_out,
    output logic [readout_pkg::WORD_W-1:0]     data_out,
    output logic                               data_oe_n,
    output logic                               busy,
    output logic                               late_read_flag,
    output logic                               conv_start,
    input  wire logic                          conv_done,
    input  wire logic [readout_pkg::WORD_W-1:0] conv_result
);
    import readout_pkg::*;

    localparam int NPIN = 9;

    generate
        if (MS_HALF_CYC < 1 || WORD_W != 2 * BYTE_W || N_BITS != WORD_W)
        begin : g_bad_cfg
            $error("readout port: unsupported width or timing");
        end
    endgenerate

    logic [NPIN-1:0]   pin_meta;
    logic [NPIN-1:0]   pin_sync;
    mode_t             mode;
    logic              cnv_q;
    logic              cs_q;
    logic              rd_q;
    logic              cnv_prev;
    logic              conv_busy;
    logic [WORD_W-1:0] last_result;
    logic              master_mode;
    logic              slave_mode;
    ms_state_t         ms_state;
    logic [3:0]        bit_idx;
    logic [3:0]        half_cnt;
    logic              sclk_raw;
    logic              ms_bit;
    logic [1:0]        ms_bit_dly;
    logic [WORD_W-1:0] ms_word;
    logic              ms_active;
    logic              next_busy;
    logic              link_sdo;
    logic              link_done_tgl;
    logic [2:0]        done_sync;
    logic              word_read;
    logic              start_edge;

    // half period of the generated clock; lengthens for low bits in during mode
    function automatic logic [3:0] half_len(input logic during,
                                            input logic [3:0] idx);
        logic [3:0] extra;
        extra = during ? (idx >> MS_SLOW_SHIFT) : 4'h0;
        half_len = 4'(MS_HALF_CYC) + extra;
    endfunction

    // two-stage sync of every pin level except sclk_in, which goes to the link unsynced
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pin_meta <= '1;
            pin_sync <= '1;
        end else begin
            pin_meta <= {convert_start_n, cs_n, rd_n, serial_parallel_sel,
                         clock_source_sel, byte_order_sel, sclk_invert_sel,
                         sync_invert_sel, read_timing_or_cascade_in};
            pin_sync <= pin_meta;
        end
    end

    assign cnv_q = pin_sync[8];
    assign cs_q  = pin_sync[7];
    assign rd_q  = pin_sync[6];

    // mode strap bits, refreshed every cycle from synced pins, except read timing, which only updates while deselected
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            mode <= MODE_RST;
        end else begin
            mode.serial      <= pin_sync[5];
            mode.ext_clk     <= pin_sync[4];
            mode.byte_swap   <= pin_sync[3];
            mode.sclk_inv    <= pin_sync[2];
            mode.sync_inv    <= pin_sync[1];
            // frozen while selected: the pin carries cascade data then
            if (cs_q && rd_q) begin
                mode.read_during <= pin_sync[0];
            end
        end
    end

    assign master_mode = mode.serial & ~mode.ext_clk;
    assign slave_mode  = mode.serial &  mode.ext_clk;
    assign start_edge  = cnv_prev & ~cnv_q & ~conv_busy;

    // falling start edge launches a conversion; no restart while busy
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cnv_prev   <= 1'b1;
            conv_busy  <= 1'b0;
            conv_start <= 1'b0;
        end else begin
            cnv_prev   <= cnv_q;
            conv_start <= start_edge;
            if (start_edge) begin
                conv_busy <= 1'b1;
            end else if (conv_done) begin
                conv_busy <= 1'b0;
            end
        end
    end

    // latest result; the previous one stays readable during conversion
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            last_result <= RESULT_RST;
        end else if (conv_done) begin
            last_result <= conv_result;
        end
    end

    // parallel bus; byte order honoured in every parallel read
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            data_out  <= '0;
            data_oe_n <= 1'b1;
        end else begin
            if (mode.byte_swap) begin
                data_out <= {last_result[BYTE_W-1:0],
                             last_result[WORD_W-1:BYTE_W]};
            end else begin
                data_out <= last_result;
            end
            data_oe_n <= cs_q | rd_q | mode.serial;
        end
    end

    // generated serial clock: during mode runs off the conversion start
    // with the previous word, after mode runs off the conversion end
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ms_state <= MS_IDLE;
            bit_idx  <= 4'h0;
            half_cnt <= 4'h0;
            sclk_raw <= 1'b0;
            ms_bit   <= 1'b0;
            ms_word  <= RESULT_RST;
        end else begin
            unique case (ms_state)
                MS_IDLE: begin
                    sclk_raw <= 1'b0;
                    bit_idx  <= 4'h0;
                    half_cnt <= 4'h0;
                    if (master_mode && mode.read_during && start_edge) begin
                        ms_word  <= last_result;
                        ms_bit   <= last_result[WORD_W-1];
                        ms_state <= MS_SHIFT;
                    end else if (master_mode && !mode.read_during
                                 && conv_done) begin
                        ms_word  <= conv_result;
                        ms_bit   <= conv_result[WORD_W-1];
                        ms_state <= MS_SHIFT;
                    end
                end
                MS_SHIFT: begin
                    if (half_cnt + 4'h1 >= half_len(mode.read_during,
                                                   bit_idx)) begin
                        half_cnt <= 4'h0;
                        sclk_raw <= ~sclk_raw;
                        // next bit picked on the raw falling edge
                        if (sclk_raw) begin
                            if (bit_idx == 4'(N_BITS - 1)) begin
                                ms_state <= MS_IDLE;
                            end else begin
                                bit_idx <= bit_idx + 4'h1;
                                ms_bit  <= ms_word[4'(N_BITS - 2)
                                                   - bit_idx];
                            end
                        end
                    end else begin
                        half_cnt <= half_cnt + 4'h1;
                    end
                end
            endcase
        end
    end

    assign ms_active = (ms_state == MS_SHIFT);

    // busy also covers the shift-out in master read-after mode
    always_comb begin
        next_busy = conv_busy | start_edge;
        if (master_mode && !mode.read_during && ms_active) begin
            next_busy = 1'b1;
        end
    end

    // clock pin driven only when we make the clock
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            busy      <= 1'b0;
            sclk_out  <= 1'b0;
            sclk_oe_n <= 1'b1;
            sync_out  <= 1'b0;
            ms_bit_dly <= 2'h0;
        end else begin
            busy      <= next_busy;
            // bit moves one cycle after the pin clock falls: margin both edges
            ms_bit_dly <= {ms_bit_dly[0], ms_bit};
            sclk_out  <= sclk_raw ^ mode.sclk_inv;
            sclk_oe_n <= ~master_mode;
            sync_out  <= ms_active ^ mode.sync_inv;
        end
    end

    // slave shifter on the host's clock; the word it reads is held
    // still by the conversion, so it is quasi-static across the domains
    slave_link u_link (
        .sclk_in    (sclk_in),
        .rstn       (rstn),
        .cs_n       (cs_n),
        .rd_n       (rd_n),
        .cascade_en (~mode.read_during),
        .word       (last_result),
        .cascade_in (read_timing_or_cascade_in),
        .sdo        (link_sdo),
        .done_tgl   (link_done_tgl)
    );

    // the cascade pin doubles as timing select, so cascade works only in
    // slave read-after mode
    assign serial_result_out = master_mode ? ms_bit_dly[1]
                                           : link_sdo;

    // word-read event back from the link; first stage feeds only second
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            done_sync <= 3'h0;
        end else begin
            done_sync <= {done_sync[1:0], link_done_tgl};
        end
    end

    // read-error pulse when the old word was not fully read in time;
    // a read finishing in the same cycle as the end still counts
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            word_read      <= 1'b1;
            late_read_flag <= 1'b0;
        end else begin
            late_read_flag <= conv_done & slave_mode & mode.read_during
                              & ~word_read
                              & ~(done_sync[2] ^ done_sync[1]);
            if (done_sync[2] ^ done_sync[1]) begin
                word_read <= 1'b1;
            end else if (conv_done) begin
                word_read <= 1'b0;
            end
        end
    end

    AST_BYTE_LOW: assert property (
        @(posedge core_clk) disable iff (!rstn)
        !mode.byte_swap |=> data_out[BYTE_W-1:0] ==
                            $past(last_result[BYTE_W-1:0]))
        else $error("low byte not on lower lines");

    AST_BYTE_SWAP: assert property (
        @(posedge core_clk) disable iff (!rstn)
        mode.byte_swap |=> data_out[WORD_W-1:BYTE_W] ==
                           $past(last_result[BYTE_W-1:0]))
        else $error("bytes not swapped");

    AST_RELEASE: assert property (
        @(posedge core_clk) disable iff (!rstn)
        (cs_q || rd_q) |=> data_oe_n)
        else $error("data driven with select or read high");

    AST_SYNC_FRAME: assert property (
        @(posedge core_clk) disable iff (!rstn)
        ms_active |=> sync_out == !$past(mode.sync_inv))
        else $error("frame signal wrong while shifting");

    AST_BUSY_TAIL: assert property (
        @(posedge core_clk) disable iff (!rstn)
        (ms_active && master_mode && !mode.read_during) |=> busy)
        else $error("busy fell before all bits out");

    AST_EXT_NODRIVE: assert property (
        @(posedge core_clk) disable iff (!rstn)
        mode.ext_clk |=> sclk_oe_n)
        else $error("clock driven in external mode");

    AST_SIXTEEN: assert property (
        @(posedge core_clk) disable iff (!rstn)
        $fell(ms_active) |-> $past(bit_idx) == 4'hF)
        else $error("frame ended before sixteen bits");

    AST_LATE_CAUSE: assert property (
        @(posedge core_clk) disable iff (!rstn)
        late_read_flag |-> $past(conv_done) && !$past(word_read))
        else $error("read error without late read");

    AST_START_BUSY: assert property (
        @(posedge core_clk) disable iff (!rstn)
        conv_start |=> busy)
        else $error("busy not raised after start");

endmodule

/* tb/host_reader.sv */
`timescale 1ns/1ps
// host side of the result port: selects, gated serial clock, cascade feed
module host_reader (
    input  wire logic sdo,
    output logic      cs_n,
    output logic      rd_n,
    output logic      sclk_in,
    output logic      cascade
);
    initial begin
        cs_n    = 1'b1;
        rd_n    = 1'b1;
        sclk_in = 1'b0;
        cascade = 1'b0;
    end

    // both selects move together, as a simple host would wire them
    task automatic select(input logic lvl);
        cs_n = lvl;
        rd_n = lvl;
    endtask

    // 64 ns gated clock, idle low; runs pre cycles deselected before each frame
    task automatic read_frame(input int n, input int pre,
                              input logic [15:0] up,
                              output logic [31:0] got);
        got = '0;
        // clocks while deselected must not advance the word
        for (int i = 0; i < pre; i++) begin
            #32 sclk_in = 1'b1;
            #32 sclk_in = 1'b0;
        end
        #13 select(1'b0);
        for (int i = 0; i < n; i++) begin
            // upstream bit set up a half period before its capture
            cascade = (i < 16) ? up[15-i] : ~cascade;
            // sample ahead of the rise: cascade bits move on it
            #32 got = {got[30:0], sdo};
            sclk_in = 1'b1;
            #32 sclk_in = 1'b0;
        end
        #13 select(1'b1);
        cascade = 1'b0;
    endtask
endmodule

/* tb/tb_adc_result_readout_port.sv */
`timescale 1ns/1ps
module tb_adc_result_readout_port;
    import readout_pkg::*;
    localparam int CONV_CYC = 60;
    logic        core_clk, rstn, convert_start_n, serial_parallel_sel;
    logic        clock_source_sel, byte_order_sel, sclk_invert_sel;
    logic        sync_invert_sel, rt_lvl, rt_pin, conv_done;
    logic        cs_n, rd_n, sclk_in, cascade, sclk_out, sclk_oe_n;
    logic        sync_out, serial_result_out, data_oe_n, busy;
    logic        late_read_flag, conv_start;
    logic [15:0] data_out, conv_result, last_res;
    int          error_cnt, n_tests, late_cnt, conv_left;

    // pin carries the fixed timing level or, in frames, cascade data
    assign rt_pin = rt_lvl | cascade;

    adc_result_readout_port adc_result_readout_port_inst (
        .core_clk(core_clk), .rstn(rstn), .convert_start_n(convert_start_n),
        .cs_n(cs_n), .rd_n(rd_n), .serial_parallel_sel(serial_parallel_sel),
        .clock_source_sel(clock_source_sel), .byte_order_sel(byte_order_sel),
        .sclk_invert_sel(sclk_invert_sel), .sync_invert_sel(sync_invert_sel),
        .read_timing_or_cascade_in(rt_pin), .sclk_in(sclk_in),
        .sclk_out(sclk_out), .sclk_oe_n(sclk_oe_n), .sync_out(sync_out),
        .serial_result_out(serial_result_out), .data_out(data_out),
        .data_oe_n(data_oe_n), .busy(busy), .late_read_flag(late_read_flag),
        .conv_start(conv_start), .conv_done(conv_done),
        .conv_result(conv_result));

    host_reader host_reader_inst (.sdo(serial_result_out), .cs_n(cs_n),
        .rd_n(rd_n), .sclk_in(sclk_in), .cascade(cascade));

    always #20 core_clk = ~core_clk;

    // conversion core of fixed length; also counts error pulses
    always @(negedge core_clk) begin
        conv_done <= (conv_left == 1);
        if (conv_start === 1'b1) begin
            conv_left <= CONV_CYC;
        end else if (conv_left > 0) begin
            conv_left <= conv_left - 1;
        end
        if (late_read_flag === 1'b1) begin
            late_cnt <= late_cnt + 1;
        end
    end

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // bounded wait on busy; a hang ends the run
    task automatic wait_busy(input logic lvl);
        int i;
        for (i = 0; i < 2000 && busy !== lvl; i++) @(negedge core_clk);
        if (i == 2000) begin
            check("busy wait", 32'(lvl), 32'(busy));
            give_verdict();
        end
    endtask

    task automatic set_mode(input logic ser, input logic ext,
                            input logic rt, input logic swap,
                            input logic inv);
        @(negedge core_clk);
        serial_parallel_sel = ser;
        clock_source_sel    = ext;
        rt_lvl              = rt;
        byte_order_sel      = swap;
        sclk_invert_sel     = inv;
        sync_invert_sel     = inv;
        repeat (4) @(negedge core_clk);
    endtask

    task automatic convert(input logic [15:0] res);
        @(negedge core_clk);
        conv_result     = res;
        convert_start_n = 1'b0;
        repeat (4) @(negedge core_clk);
        convert_start_n = 1'b1;
    endtask

    task automatic t_parallel();
        logic [15:0] r;
        r = 16'hA55C;
        set_mode(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        convert(r);
        wait_busy(1'b0);
        for (int s = 0; s < 2; s++) begin
            set_mode(1'b0, 1'b0, 1'b0, s[0], 1'b0);
            host_reader_inst.select(1'b0);
            repeat (6) @(negedge core_clk);
            check("data_oe_n", 32'h0, 32'(data_oe_n));
            check("data_out", 32'(s ? {r[7:0], r[15:8]} : r),
                  32'(data_out));
            host_reader_inst.select(1'b1);
            repeat (6) @(negedge core_clk);
            check("data_oe_n", 32'h1, 32'(data_oe_n));
        end
        last_res = r;
        $display("test parallel done");
    endtask

    task automatic t_slave_after();
        logic [31:0] got;
        set_mode(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
        convert(16'h3C96);
        wait_busy(1'b0);
        check("sclk_oe_n", 32'h1, 32'(sclk_oe_n));
        host_reader_inst.read_frame(32, 3, 16'hB1E4, got);
        check("chain word", 32'h3C96B1E4, got);
        last_res = 16'h3C96;
        $display("test slave after done");
    endtask

    task automatic t_slave_during();
        logic [31:0] got;
        int          l0;
        set_mode(1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
        l0 = late_cnt;
        convert(16'h5AF0);
        wait_busy(1'b1);
        host_reader_inst.read_frame(16, 0, 16'h0000, got);
        wait_busy(1'b0);
        check("previous word", 32'(last_res), got);
        check("late pulses", 32'(l0), 32'(late_cnt));
        // a conversion with no read at all must be flagged once
        convert(16'h0F1E);
        wait_busy(1'b0);
        repeat (3) @(negedge core_clk);
        check("late pulses", 32'(l0 + 1), 32'(late_cnt));
        last_res = 16'h0F1E;
        $display("test slave during done");
    endtask

    // watches the generated clock in its own polarity
    task automatic t_master(input logic rt, input logic inv,
                            input logic [15:0] res, input logic [15:0] exp);
        logic [15:0] w;
        logic        prev;
        int          n, gap, first, last;
        set_mode(1'b1, 1'b0, rt, 1'b0, inv);
        check("sclk idle", 32'(inv), 32'(sclk_out));
        conv_result     = res;
        convert_start_n = 1'b0;
        prev = sclk_out ^ inv;
        n    = 0;
        gap  = 0;
        for (int i = 0; i < 3000 && n < 16; i++) begin
            @(negedge core_clk);
            if (i == 3) convert_start_n = 1'b1;
            gap++;
            if ((sync_out ^ inv) && !prev && (sclk_out ^ inv)) begin
                w = {w[14:0], serial_result_out};
                if (n == 0) check("sclk_oe_n", 32'h0, 32'(sclk_oe_n));
                if (n == 1) first = gap;
                last = gap;
                gap  = 0;
                n++;
                if (n == 16 && !rt) check("busy", 32'h1, 32'(busy));
            end
            // the bit seen at the rise must still stand at the fall
            if (!(sclk_out ^ inv) && prev && n > 0) begin
                check("bit at fall", 32'(w[0]),
                      32'(serial_result_out));
            end
            prev = sclk_out ^ inv;
        end
        check("bit count", 32'd16, 32'(n));
        if (n < 16) give_verdict();
        check("master word", 32'(exp), 32'(w));
        if (rt) check("slow low bits", 32'h1, 32'(last > first));
        wait_busy(1'b0);
        repeat (12) @(negedge core_clk);
        check("frame idle", 32'h0, 32'(sync_out ^ inv));
        last_res = res;
        $display("test master done");
    endtask

    initial begin
        core_clk = 0;
        rstn = 0;
        convert_start_n = 1;
        serial_parallel_sel = 0;
        clock_source_sel = 0;
        byte_order_sel = 0;
        sclk_invert_sel = 0;
        sync_invert_sel = 0;
        rt_lvl = 0;
        conv_done = 0;
        conv_result = 16'h0000;
        last_res = 16'h0000;
        error_cnt = 0;
        n_tests = 0;
        late_cnt = 0;
        conv_left = 0;
        repeat (12) @(posedge core_clk);
        @(negedge core_clk);
        rstn = 1;
        repeat (4) @(negedge core_clk);
        t_parallel();
        t_slave_after();
        t_slave_during();
        t_master(1'b0, 1'b0, 16'hC3A1, 16'hC3A1);
        t_master(1'b1, 1'b1, 16'h7E18, 16'hC3A1);
        give_verdict();
    end
endmodule
